// file: rtl/ttcc_pkg.sv
// constants for the t1 transmit per-slot channel control block
// assumes one aclk domain and an axi4-lite register port with 32-bit data
package ttcc_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] TTCC_IDX_SLOT0 = 12'h300; // slot 0 control
    localparam logic [11:0] TTCC_IDX_SLOT23 = 12'h317; // slot 23 control
    localparam logic [11:0] TTCC_IDX_LINKSEL = 12'h10a; // link select
    localparam logic [11:0] TTCC_IDX_STATUS = 12'h318; // last octet sent
    localparam int TTCC_NSLOT = 24;
    // control register field positions
    localparam int TTCC_MC_LSB = 6; // controller select [7:6]
    localparam int TTCC_ZS_LSB = 4; // zero suppression [5:4]
    localparam int TTCC_DE_LSB = 2; // d/e source in link select [3:2]
    localparam logic [7:0] TTCC_CTRL_RESET = 8'h00;
    localparam logic [7:0] TTCC_LINK_RESET = 8'h00;
    // controller select codes
    localparam logic [1:0] TTCC_MC_1 = 2'h0;
    localparam logic [1:0] TTCC_MC_2 = 2'h1;
    localparam logic [1:0] TTCC_MC_LINK = 2'h2;
    localparam logic [1:0] TTCC_MC_3 = 2'h3;
    // zero suppression codes
    localparam logic [1:0] TTCC_ZS_NONE = 2'h0;
    localparam logic [1:0] TTCC_ZS_B7 = 2'h1;
    localparam logic [1:0] TTCC_ZS_SIG = 2'h2;
    localparam logic [1:0] TTCC_ZS_SUB = 2'h3;
    // octet values; bit 8 is the lsb, bit 7 the next one up
    localparam logic [7:0] TTCC_BIT8 = 8'h01;
    localparam logic [7:0] TTCC_BIT7 = 8'h02;
    localparam logic [7:0] TTCC_SUBST = 8'h98;
    // axi responses
    localparam logic [1:0] TTCC_OKAY = 2'h0;
    localparam logic [1:0] TTCC_SLVERR = 2'h2;
endpackage

// file: rtl/ttcc_top.sv
// t1 transmit per-slot channel control with axi4-lite registers
// assumes pcm and lapd octets arrive from logic on aclk, one per in_valid
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
module ttcc_top
    import ttcc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write channels
    input wire logic [15:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read channels
    input wire logic [15:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // transmit octet stream in
    input wire logic in_valid,
    input wire logic [4:0] in_slot,
    input wire logic [7:0] in_octet,
    input wire logic in_de_slot,
    input wire logic in_sig_frame,
    input wire logic in_sig_bit,
    input wire logic [7:0] lapd_octet1,
    input wire logic [7:0] lapd_octet2,
    input wire logic [7:0] lapd_octet3,
    input wire logic [7:0] link_octet,
    // transmit octet stream out
    output logic out_valid,
    output logic [7:0] out_octet,
    output logic [1:0] out_de_source
);

    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] slot_ctrl [0:TTCC_NSLOT-1]; // per-slot control bytes
    logic [7:0] link_sel; // signaling and link select byte
    logic [7:0] last_octet; // status: last octet sent

    // write channel holding state
    logic aw_hold;
    logic w_hold;
    logic [15:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane0_q;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    wire [11:0] wr_idx = aw_addr_q[13:2];
    wire wr_top_zero = (aw_addr_q[15:14] == 2'h0);
    wire wr_slot_hit = wr_top_zero && (wr_idx >= TTCC_IDX_SLOT0)
        && (wr_idx <= TTCC_IDX_SLOT23);
    wire wr_link_hit = wr_top_zero && (wr_idx == TTCC_IDX_LINKSEL);
    wire wr_stat_hit = wr_top_zero && (wr_idx == TTCC_IDX_STATUS);
    wire [11:0] wr_off = wr_idx - TTCC_IDX_SLOT0;
    wire [4:0] wr_slot = wr_off[4:0];
    wire wr_commit = aw_hold && w_hold && !s_bvalid;

    wire [11:0] rd_idx = s_araddr[13:2];
    wire rd_top_zero = (s_araddr[15:14] == 2'h0);
    wire rd_slot_hit = rd_top_zero && (rd_idx >= TTCC_IDX_SLOT0)
        && (rd_idx <= TTCC_IDX_SLOT23);
    wire rd_link_hit = rd_top_zero && (rd_idx == TTCC_IDX_LINKSEL);
    wire rd_stat_hit = rd_top_zero && (rd_idx == TTCC_IDX_STATUS);
    wire [11:0] rd_off = rd_idx - TTCC_IDX_SLOT0;
    wire [4:0] rd_slot = rd_off[4:0];
    wire rd_take = s_arvalid && s_arready;
    wire [7:0] rd_byte = rd_slot_hit ? slot_ctrl[rd_slot] :
        rd_link_hit ? link_sel : rd_stat_hit ? last_octet : 8'h00;
    wire rd_ok = rd_slot_hit || rd_link_hit || rd_stat_hit;

    ////////////////////////////////////////////////////////////////////////
    // write address and data, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr_q <= 16'h0000;
            w_data_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end else begin
            // ready stays low until the response is taken
            if (s_awvalid && s_awready) begin
                s_awready <= 1'b0;
                aw_hold <= 1'b1;
                aw_addr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                s_wready <= 1'b0;
                w_hold <= 1'b1;
                w_data_q <= s_wdata[7:0];
                w_lane0_q <= s_wstrb[0];
            end
            if (wr_commit) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
            end
            if (s_bvalid && s_bready) begin
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
        end
    end

    // write response; status register is read only, so it errs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_bvalid <= 1'b0;
            s_bresp <= TTCC_OKAY;
        end else if (wr_commit) begin
            s_bvalid <= 1'b1;
            s_bresp <= (wr_slot_hit || wr_link_hit) ? TTCC_OKAY : TTCC_SLVERR;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // register storage update, only the low byte lane counts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < TTCC_NSLOT; i++) begin
                slot_ctrl[i] <= TTCC_CTRL_RESET;
            end
            link_sel <= TTCC_LINK_RESET;
        end else if (wr_commit && w_lane0_q) begin
            if (wr_slot_hit) begin
                slot_ctrl[wr_slot] <= w_data_q;
            end
            if (wr_link_hit) begin
                link_sel <= w_data_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel, one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= TTCC_OKAY;
        end else if (rd_take) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata <= {24'h000000, rd_byte};
            s_rresp <= rd_ok ? TTCC_OKAY : TTCC_SLVERR;
        end else if (s_rvalid && s_rready) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-slot selection; a slot above 23 sees a zero control byte
    wire slot_ok = (in_slot < 5'd24);
    wire [7:0] cur_ctrl = slot_ok ? slot_ctrl[in_slot] : 8'h00;
    wire [1:0] mc_sel = cur_ctrl[TTCC_MC_LSB +: 2];
    wire [1:0] zs_sel = cur_ctrl[TTCC_ZS_LSB +: 2];
    wire [1:0] de_src = link_sel[TTCC_DE_LSB +: 2];
    wire octet_zero = (in_octet == 8'h00);

    // d/e slot data: controller pick, or the link path for code 10
    wire [7:0] de_octet = (mc_sel == TTCC_MC_1) ? lapd_octet1 :
        (mc_sel == TTCC_MC_2) ? lapd_octet2 :
        (mc_sel == TTCC_MC_3) ? lapd_octet3 : link_octet;

    // zero code suppression, nonzero octets always pass untouched
    logic [7:0] zs_octet;
    always_comb begin
        zs_octet = in_octet;
        if (octet_zero) begin
            case (zs_sel)
                TTCC_ZS_NONE: zs_octet = in_octet;
                TTCC_ZS_B7: zs_octet = TTCC_BIT7;
                TTCC_ZS_SIG: begin
                    if (!in_sig_frame) begin
                        zs_octet = TTCC_BIT8;
                    end else if (!in_sig_bit) begin
                        zs_octet = TTCC_BIT7;
                    end
                end
                TTCC_ZS_SUB: zs_octet = TTCC_SUBST;
                default: zs_octet = in_octet;
            endcase
        end
    end

    wire [7:0] next_octet = in_de_slot ? de_octet : zs_octet;

    ////////////////////////////////////////////////////////////////////////
    // output stage, one cycle behind the input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid <= 1'b0;
            out_octet <= 8'h00;
            out_de_source <= 2'h0;
            last_octet <= 8'h00;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_octet <= next_octet;
                last_octet <= next_octet;
                out_de_source <= de_src;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence pcm_zero_s(logic [1:0] code);
        in_valid && !in_de_slot && octet_zero && zs_sel == code;
    endsequence

    pass_nonzero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_valid && !in_de_slot && !octet_zero |=>
        out_octet == $past(in_octet))
        else $error("nonzero octet was altered");
    no_supp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pcm_zero_s(TTCC_ZS_NONE) |=> out_valid && out_octet == 8'h00)
        else $error("zero octet changed without suppression");
    bit7_stuff_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pcm_zero_s(TTCC_ZS_B7) |=> out_octet == TTCC_BIT7)
        else $error("bit 7 stuffing wrong");
    sig_bit8_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pcm_zero_s(TTCC_ZS_SIG) ##0 !in_sig_frame |=>
        out_octet == TTCC_BIT8)
        else $error("bit 8 stuffing wrong");
    sig_bit7_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pcm_zero_s(TTCC_ZS_SIG) ##0 in_sig_frame ##0 !in_sig_bit |=>
        out_octet == TTCC_BIT7)
        else $error("signaling frame bit 7 stuffing wrong");
    subst_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pcm_zero_s(TTCC_ZS_SUB) |=> out_octet == TTCC_SUBST)
        else $error("substitute octet wrong");
    ctrl_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_valid && in_de_slot && mc_sel != TTCC_MC_LINK |=>
        out_octet == (($past(mc_sel) == 2'h0) ? $past(lapd_octet1) :
        ($past(mc_sel) == 2'h1) ? $past(lapd_octet2) :
        $past(lapd_octet3)))
        else $error("wrong message controller picked");
    link_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_valid && in_de_slot && mc_sel == TTCC_MC_LINK |=>
        out_octet == $past(link_octet) &&
        out_de_source == $past(link_sel[3:2]))
        else $error("link select path wrong");
    slot_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_commit && w_lane0_q && wr_slot_hit |=>
        slot_ctrl[$past(wr_slot)] == $past(w_data_q) && s_bvalid)
        else $error("slot register not written");
    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");
endmodule

// file: test/ttcc_pcm_src.sv
// model of the system-side pcm source feeding the transmit octet stream
// assumes the bench calls send once per octet, one at a time, on aclk
module ttcc_pcm_src (
    // clock
    input wire logic aclk,
    // octet stream toward the block
    output logic in_valid,
    output logic [4:0] in_slot,
    output logic [7:0] in_octet,
    output logic in_de_slot,
    output logic in_sig_frame,
    output logic in_sig_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////
    // idle lines until the first octet
    initial begin
        in_valid = 1'b0;
        in_slot = 5'h00;
        in_octet = 8'h00;
        in_de_slot = 1'b0;
        in_sig_frame = 1'b0;
        in_sig_bit = 1'b0;
    end
    // one octet, qualifiers held only through the taking edge
    task automatic send(input logic [4:0] s, input logic [7:0] o,
                        input logic de, input logic sf, input logic sb);
        @(posedge aclk);
        in_valid <= 1'b1;
        in_slot <= s;
        in_octet <= o;
        in_de_slot <= de;
        in_sig_frame <= sf;
        in_sig_bit <= sb;
        @(posedge aclk);
        in_valid <= 1'b0;
        // stale lines are inverted so a late sample shows up as a mismatch
        in_octet <= ~o;
        in_slot <= ~s;
        in_de_slot <= ~de;
        in_sig_frame <= ~sf;
        in_sig_bit <= ~sb;
    endtask
endmodule

// file: test/ttcc_top_tb.sv
// self-checking bench for the per-slot transmit channel control block
// assumes the pcm source model and axi4-lite tasks of this file drive it
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
    $display("FAIL %s exp %h got %h", nm, e, s); end end
module ttcc_top_tb;
    import ttcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0;
    logic [15:0] s_awaddr = 0, s_araddr = 0;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0;
    logic s_arvalid = 0, s_rready = 0;
    logic [31:0] s_wdata = 0;
    logic [3:0] s_wstrb = 4'hf;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, out_de_source;
    logic [31:0] s_rdata;
    logic in_valid, in_de_slot, in_sig_frame, in_sig_bit, out_valid;
    logic [4:0] in_slot;
    logic [7:0] in_octet, out_octet, l1 = 0, l2 = 0, l3 = 0, lk = 0;
    logic [7:0] ctrl [24]; // shadow of the slot control bytes
    logic [7:0] link = 0, last = 0; // shadow link select, last octet out
    logic [31:0] seed = 32'he6edcde3;
    int fails = 0, n_compared = 0;
    always #20 aclk = ~aclk; // 25 mhz
    ////////////////////////////////////////////////////////////////////////
    ttcc_top dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .in_valid(in_valid), .in_slot(in_slot),
        .in_octet(in_octet), .in_de_slot(in_de_slot),
        .in_sig_frame(in_sig_frame), .in_sig_bit(in_sig_bit),
        .lapd_octet1(l1), .lapd_octet2(l2), .lapd_octet3(l3),
        .link_octet(lk), .out_valid(out_valid), .out_octet(out_octet),
        .out_de_source(out_de_source));
    ttcc_pcm_src src (.aclk(aclk), .in_valid(in_valid), .in_slot(in_slot),
        .in_octet(in_octet), .in_de_slot(in_de_slot),
        .in_sig_frame(in_sig_frame), .in_sig_bit(in_sig_bit));
    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic finish_test();
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] byte_addr(logic [11:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
    // expected line octet for one input octet
    function automatic logic [7:0] exp_oct(logic [7:0] c, logic [7:0] o,
                                            logic de, logic sf, logic sb);
        if (de)
            case (c[7:6])
                TTCC_MC_1: return l1;
                TTCC_MC_2: return l2;
                TTCC_MC_3: return l3;
                default: return lk;
            endcase
        if (o != 8'h00)
            return o; // nonzero octets never altered
        case (c[5:4])
            TTCC_ZS_NONE: return 8'h00;
            TTCC_ZS_B7: return TTCC_BIT7;
            TTCC_ZS_SIG: return !sf ? TTCC_BIT8 : (!sb ? TTCC_BIT7 : 8'h00);
            default: return TTCC_SUBST;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write: both channels offered together, wait for response
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= {24'h0, d};
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid && n < 50);
        s_bready <= 1'b0;
        r = s_bresp;
        if (!s_bvalid) begin
            fails++;
            finish_test();
        end
    endtask
    // axi4-lite read
    task automatic rd(input logic [15:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid && n < 50);
        s_rready <= 1'b0;
        d = s_rdata;
        r = s_rresp;
        if (!s_rvalid) begin
            fails++;
            finish_test();
        end
    endtask
    // one octet through the stream with fresh controller octets
    task automatic tx(input logic [4:0] s, input logic [7:0] o,
                      input logic de, input logic sf, input logic sb);
        logic [7:0] e;
        @(posedge aclk);
        {l1, l2, l3, lk} <= xs();
        @(posedge aclk);
        e = exp_oct(s < 24 ? ctrl[s] : 8'h00, o, de, sf, sb);
        src.send(s, o, de, sf, sb);
        #1;
        `CHK("out_valid", 1'b1, out_valid)
        if (de) `CHK("de_octet", e, out_octet)
        else `CHK("zs_octet", e, out_octet)
        `CHK("de_source", link[3:2], out_de_source)
        last = e;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [31:0] x;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            rd(byte_addr(TTCC_IDX_SLOT0 + 12'(i)), d, r);
            `CHK("slot_reset", {TTCC_OKAY, 32'h0}, {r, d})
        end
        rd(16'h0004, d, r); // unmapped place
        `CHK("unmapped_rd", {TTCC_SLVERR, 32'h0}, {r, d})
        wr(byte_addr(TTCC_IDX_STATUS), 8'h55, r); // read-only place
        `CHK("status_wr", TTCC_SLVERR, r)
        for (int i = 0; i < 24; i++) begin
            ctrl[i] = 8'(xs());
            wr(byte_addr(TTCC_IDX_SLOT0 + 12'(i)), ctrl[i], r);
            `CHK("slot_wr", TTCC_OKAY, r)
        end
        for (int i = 0; i < 24; i++) begin
            rd(byte_addr(TTCC_IDX_SLOT0 + 12'(i)), d, r);
            `CHK("slot_rb", {TTCC_OKAY, 24'h0, ctrl[i]}, {r, d})
        end
        // low byte lane off: write answered but the byte is kept
        s_wstrb <= 4'he;
        wr(byte_addr(TTCC_IDX_SLOT0), ~ctrl[0], r);
        s_wstrb <= 4'hf;
        `CHK("lane_off_wr", TTCC_OKAY, r)
        rd(byte_addr(TTCC_IDX_SLOT0), d, r);
        `CHK("lane_off_rb", {TTCC_OKAY, 24'h0, ctrl[0]}, {r, d})
        // every select code, every frame kind, on an all-zero octet
        for (int k = 0; k < 128; k++) begin
            ctrl[23] = {4'(k), 4'h0};
            wr(byte_addr(TTCC_IDX_SLOT23), ctrl[23], r);
            tx(5'd23, 8'h00, k[4], k[5], k[6]);
        end
        // random traffic, control and link select rewritten now and then
        for (int k = 0; k < 300; k++) begin
            x = xs();
            if (x[2:0] == 3'h0) begin
                ctrl[x[12:8] % 24] = x[23:16];
                wr(byte_addr(TTCC_IDX_SLOT0 + 12'(x[12:8] % 24)),
                   x[23:16], r);
            end
            if (x[5:3] == 3'h0) begin
                link = x[31:24];
                wr(byte_addr(TTCC_IDX_LINKSEL), link, r);
            end
            tx(x[12:8], x[6] ? x[31:24] : 8'h00, x[7], x[13], x[14]);
        end
        rd(byte_addr(TTCC_IDX_STATUS), d, r);
        `CHK("status_rd", {TTCC_OKAY, 24'h0, last}, {r, d})
        rd(byte_addr(TTCC_IDX_LINKSEL), d, r);
        `CHK("link_rb", {TTCC_OKAY, 24'h0, link}, {r, d})
        finish_test();
    end
endmodule
